// file: design/fbms_map.vh
/*
  Constants of the fieldbus master link supervisor: APB offsets, field
  positions, reset values, error codes and timing figures.
  Assumes a 20 MHz core clock and 32-bit APB data.
*/
`ifndef FBMS_MAP_VH
`define FBMS_MAP_VH

`define FBMS_ADDR_W        8
`define FBMS_OFS_CTRL      8'h00
`define FBMS_OFS_RELAY     8'h04
`define FBMS_OFS_UNLINK0   8'h08
`define FBMS_OFS_UNLINK1   8'h0c
`define FBMS_OFS_UNLINK2   8'h10
`define FBMS_OFS_UNLINK3   8'h14
`define FBMS_OFS_CFG0      8'h18
`define FBMS_OFS_CFG1      8'h1c
`define FBMS_OFS_CFG2      8'h20
`define FBMS_OFS_CFG3      8'h24
`define FBMS_OFS_STATUS    8'h28

`define FBMS_CTRL_LINK_HI  2
`define FBMS_CTRL_LINK_LO  0
`define FBMS_CTRL_STOP     3
`define FBMS_CTRL_RESET    4'h8

`define FBMS_ST_STATE_HI   2
`define FBMS_ST_STATE_LO   0
`define FBMS_ST_ERR        3
`define FBMS_ST_XCHG       4
`define FBMS_ST_BUSOFF     5
`define FBMS_ST_CHANGED    6
`define FBMS_ST_CODE_HI    15
`define FBMS_ST_CODE_LO    8
`define FBMS_ST_SLV_HI     21
`define FBMS_ST_SLV_LO     16

`define FBMS_MAP_ZERO      64'h0000_0000_0000_0000
`define FBMS_SLAVE_MASK    64'hffff_ffff_ffff_fffe
`define FBMS_ZERO_8        8'h00
`define FBMS_ZERO_16       16'h0000
`define FBMS_ZERO_32       32'h0000_0000
`define FBMS_ZERO_NODE     6'h00

`define FBMS_ERR_NONE      8'h00
`define FBMS_ERR_COMM      8'hd9
`define FBMS_ERR_TRANS     8'he2
`define FBMS_ERR_BUSOFF    8'hf1
`define FBMS_ERR_DUP       8'hd0

`define FBMS_CLK_KHZ       20000
`define FBMS_RECOVER_MS    18000
`define FBMS_STARTUP_MS    6600
`define FBMS_PHASES        3

`endif

// file: design/fbms_first_one.v
/*
  Lowest-set-bit finder over a 64-bit node map; returns the node address.
  Purely combinational, assumes the caller registers the result.
*/
`timescale 1ns/100ps
module fbms_first_one
(
  input  wire [63:0] map_in,
  output wire [5:0]  node_out
);
  wire [5:0] chain [0:64];

  assign chain[64] = 6'h00;

  genvar i;
  generate
    for (i = 0; i < 64; i = i + 1)
    begin : g_bit
      // Sized copy of the index keeps the select free of a genvar slice
      localparam [5:0] NODE = i;
      assign chain[i] = map_in[i] ? NODE : chain[i + 1];
    end
  endgenerate

  assign node_out = chain[0];
endmodule

// file: design/fbms_supervisor.v
/*
  Fieldbus master link supervisor: start-up sequence, slave recovery
  window, error latching, communication reset and unlinking of slaves.
  Assumes an APB master on core_clk_in, slave status pins from the link
  side (synchronised here) and a same-clock I/O data stream.
*/
// Summary of operation
// R01: Tolerate slave silence up to 18 s with recovery, then report error.
// R02: Latched error clears only by CPU restart or communication reset.
// R03: Lost slave not unlinked reports error and stops all exchange.
// R04: Control bit selects stop or continue on communication error.
// R05: Start-up to established exchange takes about 6.6 s.
// R06: Check duplicate address, read parameters, confirm slaves, then run.
// R07: Communication reset acts on OFF-to-ON edge of its relay only.
// R08: Eight relay bits, one per link number 1 to 8, consecutive.
// R09: Reset request honoured only while an error is latched.
// R10: Reset ignored in transmission error and bus-off; bus-off needs power.
// R11: CPU restart resets only if parameters changed and error exists.
// R12: Unlinked slave gets all-OFF outputs; its inputs read all-OFF.
// R13: Unlinked slaves exchange OFF data right from start or reset.
// R14: Lost unlinked slave keeps retrying; others exchange normally.
// R15: Lost unlinked slave reports comm error code and node, no stop.
// R16: All slaves unlinked and all lost reports transmission error.
// R17: Withdrawn unlink: normal slave exchanges, lost slave stops all.
// R18: The network holds one master; all other nodes are slaves.
// R19: Unlink map is 64 bits in four 16-bit registers, bit is node.
// R20: Master is node 00; slaves are nodes 01 to 63.
// R21: Error code and slave number stay latched until a valid reset; bus-off and transmission error overwrite them here.
`timescale 1ns/100ps
`include "fbms_map.vh"
module fbms_supervisor
#(
  parameter RECOVER_CYC = `FBMS_RECOVER_MS * `FBMS_CLK_KHZ,
  parameter PHASE_CYC   = `FBMS_STARTUP_MS * `FBMS_CLK_KHZ / `FBMS_PHASES
)
(
  input  wire        core_clk_in,
  input  wire        reset_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire        cpu_restart_in,
  input  wire [63:0] slave_ok_in,
  input  wire        busoff_in,
  input  wire        dup_addr_in,
  input  wire        tx_valid_in,
  input  wire [5:0]  tx_node_in,
  input  wire [7:0]  tx_data_in,
  input  wire        rx_valid_in,
  input  wire [5:0]  rx_node_in,
  input  wire [7:0]  rx_data_in,
  output reg         tx_valid_out,
  output reg  [5:0]  tx_node_out,
  output reg  [7:0]  tx_data_out,
  output reg         rx_valid_out,
  output reg  [5:0]  rx_node_out,
  output reg  [7:0]  rx_data_out,
  output reg         exchanging_out,
  output reg         comm_error_out,
  output reg  [7:0]  error_code_out,
  output reg  [5:0]  error_node_out
);
  localparam ST_DUP   = 3'd0;
  localparam ST_PARAM = 3'd1;
  localparam ST_CONF  = 3'd2;
  localparam ST_RUN   = 3'd3;
  localparam ST_STOP  = 3'd4;

  reg  [3:0]  ctrl;
  reg  [7:0]  relay;
  reg  [7:0]  relay_prev;
  reg  [63:0] unlink;
  reg  [63:0] cfg;
  reg         changed;
  reg  [2:0]  state;
  reg  [31:0] phase_cnt;
  reg  [31:0] rec_cnt;
  reg  [63:0] lost;
  reg         busoff;
  reg  [63:0] ok_meta;
  reg  [63:0] ok_sync;
  reg  [1:0]  bo_meta;
  reg  [1:0]  dup_meta;

  wire        bo_sync  = bo_meta[1];
  wire        dup_sync = dup_meta[1];
  wire        acc      = psel_in & penable_in;
  wire        wr_done  = acc & pready_out & pwrite_in;
  wire [2:0]  link_sel = ctrl[`FBMS_CTRL_LINK_HI:`FBMS_CTRL_LINK_LO];
  wire        stop_cfg = ctrl[`FBMS_CTRL_STOP];
  wire [63:0] cfg_eff  = cfg & `FBMS_SLAVE_MASK; // R20
  wire [63:0] down     = cfg_eff & ~ok_sync;
  wire [63:0] pending  = down & ~lost;
  wire        running  = (state == ST_RUN);
  wire        expire   = running && (pending != `FBMS_MAP_ZERO) &&
                         (rec_cnt == RECOVER_CYC - 1);
  wire [63:0] next_lost = (lost & down) | (expire ? down : `FBMS_MAP_ZERO);
  wire [63:0] fatal_map = next_lost & ~unlink & cfg_eff;
  wire [63:0] unl_new   = expire ? (pending & unlink) : `FBMS_MAP_ZERO;
  wire        all_unl   = (cfg_eff != `FBMS_MAP_ZERO) &&
                          ((cfg_eff & ~unlink) == `FBMS_MAP_ZERO);
  wire        all_lost  = all_unl && (next_lost == cfg_eff);
  wire        err       = comm_error_out;
  wire        relay_rise = relay[link_sel] & ~relay_prev[link_sel]; // R07
  wire        reset_ok  = relay_rise & err & ~busoff &
                          (error_code_out != `FBMS_ERR_TRANS); // R09 R10
  wire        cpu_ok    = cpu_restart_in & changed & err; // R11
  wire        restart   = reset_ok | cpu_ok; // R02
  wire [5:0]  fatal_node;
  wire [5:0]  unl_node;

  fbms_first_one u_fatal
  (
    .map_in   (fatal_map),
    .node_out (fatal_node)
  );

  fbms_first_one u_unl
  (
    .map_in   (unl_new),
    .node_out (unl_node)
  );

  // Pins from the link side: two flops before any use
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      ok_meta  <= `FBMS_MAP_ZERO;
      ok_sync  <= `FBMS_MAP_ZERO;
      bo_meta  <= 2'b00;
      dup_meta <= 2'b00;
    end
    else
    begin
      ok_meta  <= slave_ok_in;
      ok_sync  <= ok_meta;
      bo_meta  <= {bo_meta[0], busoff_in};
      dup_meta <= {dup_meta[0], dup_addr_in};
    end
  end

  // APB slave: one wait state, write lands on the completing edge
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= `FBMS_ZERO_32;
    end
    else if (acc && !pready_out)
    begin
      pready_out  <= 1'b1;
      pslverr_out <= 1'b0;
      prdata_out  <= `FBMS_ZERO_32;
      case (paddr_in)
        `FBMS_OFS_CTRL:    prdata_out[3:0] <= ctrl;
        `FBMS_OFS_RELAY:   prdata_out[7:0] <= relay;
        `FBMS_OFS_UNLINK0: prdata_out[15:0] <= unlink[15:0];
        `FBMS_OFS_UNLINK1: prdata_out[15:0] <= unlink[31:16];
        `FBMS_OFS_UNLINK2: prdata_out[15:0] <= unlink[47:32];
        `FBMS_OFS_UNLINK3: prdata_out[15:0] <= unlink[63:48];
        `FBMS_OFS_CFG0:    prdata_out[15:0] <= cfg[15:0];
        `FBMS_OFS_CFG1:    prdata_out[15:0] <= cfg[31:16];
        `FBMS_OFS_CFG2:    prdata_out[15:0] <= cfg[47:32];
        `FBMS_OFS_CFG3:    prdata_out[15:0] <= cfg[63:48];
        `FBMS_OFS_STATUS:
        begin
          prdata_out[`FBMS_ST_STATE_HI:`FBMS_ST_STATE_LO] <= state;
          prdata_out[`FBMS_ST_ERR]     <= comm_error_out;
          prdata_out[`FBMS_ST_XCHG]    <= exchanging_out;
          prdata_out[`FBMS_ST_BUSOFF]  <= busoff;
          prdata_out[`FBMS_ST_CHANGED] <= changed;
          prdata_out[`FBMS_ST_CODE_HI:`FBMS_ST_CODE_LO] <= error_code_out;
          prdata_out[`FBMS_ST_SLV_HI:`FBMS_ST_SLV_LO]   <= error_node_out;
        end
        default:           pslverr_out <= 1'b1;
      endcase
    end
    else
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // Software registers; the unlink map is four 16-bit words
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      ctrl       <= `FBMS_CTRL_RESET;
      relay      <= `FBMS_ZERO_8;
      relay_prev <= `FBMS_ZERO_8;
      unlink     <= `FBMS_MAP_ZERO;
      cfg        <= `FBMS_MAP_ZERO;
      changed    <= 1'b0;
    end
    else
    begin
      relay_prev <= relay;
      if (restart)
        changed <= 1'b0;
      if (wr_done)
      begin
        case (paddr_in)
          `FBMS_OFS_CTRL:
          begin
            ctrl    <= pwdata_in[3:0];
            changed <= 1'b1;
          end
          `FBMS_OFS_RELAY:   relay <= pwdata_in[7:0]; // R08
          `FBMS_OFS_UNLINK0: unlink[15:0]  <= pwdata_in[15:0]; // R19
          `FBMS_OFS_UNLINK1: unlink[31:16] <= pwdata_in[15:0]; // R19
          `FBMS_OFS_UNLINK2: unlink[47:32] <= pwdata_in[15:0]; // R19
          `FBMS_OFS_UNLINK3: unlink[63:48] <= pwdata_in[15:0]; // R19
          `FBMS_OFS_CFG0:
          begin
            cfg[15:0] <= pwdata_in[15:0];
            changed   <= 1'b1;
          end
          `FBMS_OFS_CFG1:
          begin
            cfg[31:16] <= pwdata_in[15:0];
            changed    <= 1'b1;
          end
          `FBMS_OFS_CFG2:
          begin
            cfg[47:32] <= pwdata_in[15:0];
            changed    <= 1'b1;
          end
          `FBMS_OFS_CFG3:
          begin
            cfg[63:48] <= pwdata_in[15:0];
            changed    <= 1'b1;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // Start-up sequence, recovery window and error latching
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      state          <= ST_DUP;
      phase_cnt      <= `FBMS_ZERO_32;
      rec_cnt        <= `FBMS_ZERO_32;
      lost           <= `FBMS_MAP_ZERO;
      busoff         <= 1'b0;
      comm_error_out <= 1'b0;
      error_code_out <= `FBMS_ERR_NONE;
      error_node_out <= `FBMS_ZERO_NODE;
    end
    else if (bo_sync || busoff)
    begin
      // Only power, i.e. reset_in, leaves bus-off
      busoff         <= 1'b1; // R10
      state          <= ST_STOP;
      if (!busoff)
      begin
        comm_error_out <= 1'b1;
        error_code_out <= `FBMS_ERR_BUSOFF;
        error_node_out <= `FBMS_ZERO_NODE;
      end
    end
    else if (restart)
    begin
      state          <= ST_DUP; // R13
      phase_cnt      <= `FBMS_ZERO_32;
      rec_cnt        <= `FBMS_ZERO_32;
      lost           <= `FBMS_MAP_ZERO;
      comm_error_out <= 1'b0; // R21
      error_code_out <= `FBMS_ERR_NONE;
      error_node_out <= `FBMS_ZERO_NODE;
    end
    else
    begin
      case (state)
        ST_DUP, ST_PARAM, ST_CONF:
        begin
          if (state == ST_DUP && dup_sync)
          begin
            state          <= ST_STOP; // R06
            comm_error_out <= 1'b1;
            error_code_out <= `FBMS_ERR_DUP;
            error_node_out <= `FBMS_ZERO_NODE;
          end
          else if (phase_cnt == PHASE_CYC - 1)
          begin
            phase_cnt <= `FBMS_ZERO_32;
            state     <= state + 3'd1; // R05 R06
          end
          else
            phase_cnt <= phase_cnt + 32'd1;
        end
        ST_RUN:
        begin
          // One window serves every silent slave still being retried
          if (pending == `FBMS_MAP_ZERO || expire)
            rec_cnt <= `FBMS_ZERO_32; // R01
          else
            rec_cnt <= rec_cnt + 32'd1; // R01
          lost <= next_lost; // R14
          if (fatal_map != `FBMS_MAP_ZERO)
          begin
            if (stop_cfg)
              state <= ST_STOP; // R03 R04 R17
            if (!err)
            begin
              comm_error_out <= 1'b1; // R03
              error_code_out <= `FBMS_ERR_COMM;
              error_node_out <= fatal_node;
            end
          end
          else if (all_lost)
          begin
            if (!err || error_code_out != `FBMS_ERR_TRANS)
            begin
              comm_error_out <= 1'b1; // R16
              error_code_out <= `FBMS_ERR_TRANS;
              error_node_out <= `FBMS_ZERO_NODE;
            end
          end
          else if (unl_new != `FBMS_MAP_ZERO && !err)
          begin
            comm_error_out <= 1'b1; // R15
            error_code_out <= `FBMS_ERR_COMM;
            error_node_out <= unl_node;
          end
        end
        ST_STOP:
        begin
        end
        default:
          state <= ST_STOP;
      endcase
    end
  end

  // Data stream: unlinked or lost slaves see and give all-OFF data
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      exchanging_out <= 1'b0;
      tx_valid_out   <= 1'b0;
      tx_node_out    <= `FBMS_ZERO_NODE;
      tx_data_out    <= `FBMS_ZERO_8;
      rx_valid_out   <= 1'b0;
      rx_node_out    <= `FBMS_ZERO_NODE;
      rx_data_out    <= `FBMS_ZERO_8;
    end
    else
    begin
      exchanging_out <= running;
      tx_valid_out   <= tx_valid_in & running;
      tx_node_out    <= tx_node_in;
      rx_valid_out   <= rx_valid_in & running;
      rx_node_out    <= rx_node_in;
      if (unlink[tx_node_in] || lost[tx_node_in])
        tx_data_out <= `FBMS_ZERO_8; // R12 R13 R17
      else
        tx_data_out <= tx_data_in;
      if (unlink[rx_node_in] || lost[rx_node_in])
        rx_data_out <= `FBMS_ZERO_8; // R12 R14
      else
        rx_data_out <= rx_data_in;
    end
  end
endmodule

// file: bench/fbms_props.sv
/* Port checker of the link supervisor, bound to fbms_supervisor.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module fbms_props
#(
  parameter RECOVER_CYC = 50,
  parameter PHASE_CYC   = 10
)
(
  input wire       core_clk_in,
  input wire       reset_in,
  input wire       psel_in,
  input wire       penable_in,
  input wire       pwrite_in,
  input wire [7:0] paddr_in,
  input wire       pready_out,
  input wire       cpu_restart_in,
  input wire       busoff_in,
  input wire       tx_valid_in,
  input wire [5:0] tx_node_in,
  input wire [7:0] tx_data_in,
  input wire       tx_valid_out,
  input wire [5:0] tx_node_out,
  input wire [7:0] tx_data_out,
  input wire       exchanging_out,
  input wire       comm_error_out,
  input wire [7:0] error_code_out,
  input wire [5:0] error_node_out
);
  reg  [3:0]  clr_age;
  reg  [15:0] since;
  // Refused requests count too: loosens a_clear_cause and a_code_held, but restarts since for a_start_time
  wire        clr_req = cpu_restart_in | (psel_in & penable_in &
                        pready_out & pwrite_in & (paddr_in == 8'h04));
  always @(posedge core_clk_in)
  begin
    if (reset_in | clr_req)
    begin
      clr_age <= 4'h8;
      since   <= 16'h0000;
    end
    else
    begin
      if (clr_age != 4'h0)
        clr_age <= clr_age - 4'h1;
      if (since != 16'hffff)
        since <= since + 16'h0001;
    end
  end
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  sequence s_setup;
    psel_in && !penable_in ##1 psel_in && penable_in;
  endsequence
  sequence s_answer;
    !pready_out ##1 pready_out;
  endsequence
  a_one_wait: assert property (s_setup |-> s_answer)
    else $error("pready not in second access cycle");
  a_stream_copy: assert property (tx_valid_out |-> $past(tx_valid_in) &&
    tx_node_out == $past(tx_node_in) &&
    (tx_data_out == $past(tx_data_in) || tx_data_out == 8'h00))
    else $error("stream output not a copy or all off");
  a_valid_in_run: assert property (tx_valid_out |-> ##[0:1]
    (exchanging_out || $past(exchanging_out)))
    else $error("stream valid outside exchange");
  a_clear_cause: assert property ($fell(comm_error_out) |-> clr_age != 0)
    else $error("error cleared without reset request");
  a_code_held: assert property (comm_error_out && $past(comm_error_out) &&
    clr_age == 4'h0 |-> ($stable(error_code_out) &&
    $stable(error_node_out)) || error_code_out == 8'he2)
    else $error("latched error changed");
  a_err_has_code: assert property (comm_error_out |-> error_code_out != 0)
    else $error("error without code");
  a_busoff_report: assert property ($rose(busoff_in) && !comm_error_out
    |-> ##[1:8] comm_error_out && error_code_out == 8'hf1 &&
    error_node_out == 6'h00)
    else $error("bus off not reported");
  a_busoff_sticky: assert property (error_code_out == 8'hf1 |=>
    error_code_out == 8'hf1)
    else $error("bus off code left");
  a_start_time: assert property ($rose(exchanging_out) |->
    since >= 3 * PHASE_CYC && since <= 3 * PHASE_CYC + 6)
    else $error("exchange start time wrong");
endmodule
bind fbms_supervisor fbms_props #(.RECOVER_CYC(RECOVER_CYC),
  .PHASE_CYC(PHASE_CYC)) u_props (.core_clk_in(core_clk_in),
  .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pready_out(pready_out),
  .cpu_restart_in(cpu_restart_in), .busoff_in(busoff_in),
  .tx_valid_in(tx_valid_in), .tx_node_in(tx_node_in),
  .tx_data_in(tx_data_in), .tx_valid_out(tx_valid_out),
  .tx_node_out(tx_node_out), .tx_data_out(tx_data_out),
  .exchanging_out(exchanging_out), .comm_error_out(comm_error_out),
  .error_code_out(error_code_out), .error_node_out(error_node_out));

// file: bench/fbms_slaves.sv
/* Slave stations on the far side: response levels and a cyclic
   input stream from nodes 1 to 3. Assumes the bench picks which
   nodes fall silent. */
`timescale 1ns/100ps
module fbms_slaves
(
  input  wire        clk_in,
  input  wire [63:0] down_in,
  output wire [63:0] slave_ok_out,
  output wire        rx_valid_out,
  output reg  [5:0]  rx_node_out,
  output wire [7:0]  rx_data_out
);
  initial rx_node_out = 6'h01;
  // Node 0 is the master and never answers as a slave
  assign slave_ok_out = ~down_in & 64'hffff_ffff_ffff_fffe;
  assign rx_valid_out = ~down_in[rx_node_out];
  // A silent node leaves junk, not its last value
  assign rx_data_out = {2'b11, rx_node_out} ^ {8{~rx_valid_out}};
  always @(posedge clk_in)
  begin
    if (rx_node_out == 6'h03)
      rx_node_out <= 6'h01;
    else
      rx_node_out <= rx_node_out + 6'h01;
  end
endmodule

// file: bench/tb_top.sv
/* Bench of the link supervisor: APB and stream tasks drive it while
   fbms_slaves plays the slaves. Assumes shortened window counts. */
`timescale 1ns/100ps
`include "fbms_map.vh"
module tb_top;
  localparam [7:0] CTL = `FBMS_OFS_CTRL;
  localparam [7:0] RLY = `FBMS_OFS_RELAY;
  localparam [7:0] STS = `FBMS_OFS_STATUS;
  reg         clk, reset, psel, penable, pwrite, cpu_restart;
  reg         busoff, dup_addr, tx_valid, slverr;
  reg  [7:0]  paddr, tx_data;
  reg  [5:0]  tx_node;
  reg  [31:0] pwdata, rd;
  reg  [63:0] down, unl;
  integer     bad_count, total_checks, m;
  wire [31:0] prdata;
  wire        pready, pslverr, rx_valid, txv_o, rxv_o, exch, err;
  wire [63:0] slave_ok;
  wire [5:0]  rx_node, txn_o, rxn_o, enode;
  wire [7:0]  rx_data, txd_o, rxd_o, code;
  wire [31:0] trio = {16'h0, exch, err, code, enode};
  fbms_supervisor #(.RECOVER_CYC(50), .PHASE_CYC(10)) dut
  (
    .core_clk_in(clk), .reset_in(reset), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .cpu_restart_in(cpu_restart),
    .slave_ok_in(slave_ok), .busoff_in(busoff), .dup_addr_in(dup_addr),
    .tx_valid_in(tx_valid), .tx_node_in(tx_node), .tx_data_in(tx_data),
    .rx_valid_in(rx_valid), .rx_node_in(rx_node), .rx_data_in(rx_data),
    .tx_valid_out(txv_o), .tx_node_out(txn_o), .tx_data_out(txd_o),
    .rx_valid_out(rxv_o), .rx_node_out(rxn_o), .rx_data_out(rxd_o),
    .exchanging_out(exch), .comm_error_out(err),
    .error_code_out(code), .error_node_out(enode)
  );
  fbms_slaves slaves
  (
    .clk_in(clk), .down_in(down), .slave_ok_out(slave_ok),
    .rx_valid_out(rx_valid), .rx_node_out(rx_node), .rx_data_out(rx_data)
  );
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task complete_run;
  begin
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [95:0] what, input [31:0] exp, input [31:0] got);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("wrong value %0s exp %h got %h", what, exp, got);
    end
  end
  endtask
  task give_up;
  begin
    bad_count = bad_count + 1;
    complete_run;
  end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    integer n;
  begin
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 9)
    begin
      @(posedge clk);
      n = n + 1;
    end
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      give_up;
    @(posedge clk);
  end
  endtask
  task wait_on(input sel, input lvl, input integer lim);
    integer n;
  begin
    n = 0;
    while ((sel ? err : exch) !== lvl && n < lim)
    begin
      @(posedge clk);
      n = n + 1;
    end
    if ((sel ? err : exch) !== lvl)
      give_up;
  end
  endtask
  task tx_chk(input [5:0] nd, input [7:0] d, input [7:0] e);
  begin
    tx_valid <= 1'b1;
    tx_node <= nd;
    tx_data <= d;
    @(posedge clk);
    tx_valid <= 1'b0;
    @(posedge clk);
    chk("tx", {17'h0, 1'b1, nd, e}, {17'h0, txv_o, txn_o, txd_o});
  end
  endtask
  task rx_chk;
    integer i;
    reg [5:0] nd;
  begin
    // Node the model offers at this edge comes out one cycle later
    nd = rx_node;
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge clk);
      chk("rx", {17'h0, 1'b1, nd, unl[nd] ? 8'h00 : {2'b11, nd}},
          {17'h0, rxv_o, rxn_o, rxd_o});
      nd = rx_node;
    end
  end
  endtask
  task pulse;
  begin
    cpu_restart <= 1'b1;
    @(posedge clk);
    cpu_restart <= 1'b0;
    @(posedge clk);
  end
  endtask
  task do_reset;
  begin
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  end
  endtask
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_restart = 1'b0;
    busoff = 1'b0;
    dup_addr = 1'b0;
    tx_valid = 1'b0;
    tx_node = 6'h00;
    tx_data = 8'h00;
    down = 64'h0;
    unl = 64'h4;
    bad_count = 0;
    total_checks = 0;
    do_reset;
    apb(0, CTL, 0);
    chk("ctrl", 32'h8, rd);
    apb(0, 8'h2c, 0);
    chk("unmapped", 32'h1, {31'h0, slverr} | rd);
    apb(1, `FBMS_OFS_CFG0, 32'he);
    apb(1, `FBMS_OFS_UNLINK0, 32'h4);
    wait_on(0, 1, 200);
    apb(0, STS, 0);
    chk("status", 32'h13, rd & 32'h3f);
    tx_chk(6'h01, 8'ha5, 8'ha5);
    tx_chk(6'h02, 8'ha5, 8'h00);
    rx_chk;
    pulse;
    apb(1, RLY, 0);
    apb(1, RLY, 1);
    repeat (4) @(posedge clk);
    apb(0, STS, 0);
    chk("no reset", 32'h13, rd & 32'h3f);
    down <= 64'h4;
    repeat (40) @(posedge clk);
    chk("window", 0, {31'h0, err});
    wait_on(1, 1, 100);
    repeat (3) @(posedge clk);
    tx_chk(6'h01, 8'h5a, 8'h5a);
    chk("unl lost", {16'h0, 2'b11, 8'hd9, 6'h02}, trio);
    apb(1, `FBMS_OFS_UNLINK0, 32'h0);
    repeat (3) @(posedge clk);
    chk("withdrawn", {16'h0, 2'b01, 8'hd9, 6'h02}, trio);
    apb(1, `FBMS_OFS_UNLINK0, 32'h4);
    down <= 64'h0;
    apb(1, RLY, 1);
    chk("steady", 32'h1, {31'h0, err});
    apb(1, CTL, 32'ha);
    apb(1, RLY, 0);
    apb(1, RLY, 1);
    chk("other link", {16'h0, 2'b01, 8'hd9, 6'h02}, trio);
    apb(1, RLY, 4);
    repeat (4) @(posedge clk);
    chk("cleared", 0, {31'h0, err});
    wait_on(0, 1, 200);
    tx_chk(6'h02, 8'ha5, 8'h00);
    for (m = 0; m < 2; m = m + 1)
    begin
      apb(1, CTL, {28'h0, m[0], 3'h2});
      down <= 64'h2;
      wait_on(1, 1, 200);
      repeat (4) @(posedge clk);
      chk("lost", {16'h0, ~m[0], 1'b1, 8'hd9, 6'h01}, trio);
      down <= 64'h0;
      apb(1, RLY, 0);
      apb(1, RLY, 4);
      repeat (4) @(posedge clk);
      wait_on(0, 1, 200);
    end
    apb(1, CTL, 32'ha);
    down <= 64'h2;
    wait_on(1, 1, 200);
    down <= 64'h0;
    repeat (4) @(posedge clk);
    pulse;
    wait_on(0, 1, 200);
    chk("cpu reset", 0, {31'h0, err});
    unl = 64'he;
    apb(1, `FBMS_OFS_UNLINK0, 32'he);
    down <= 64'he;
    wait_on(1, 1, 200);
    repeat (4) @(posedge clk);
    apb(1, RLY, 0);
    apb(1, RLY, 4);
    repeat (4) @(posedge clk);
    chk("all lost", {16'h0, 2'b11, 8'he2, 6'h00}, trio);
    down <= 64'h0;
    do_reset;
    busoff <= 1'b1;
    wait_on(1, 1, 20);
    apb(1, RLY, 0);
    apb(1, RLY, 1);
    chk("bus off", {16'h0, 2'b01, 8'hf1, 6'h00}, trio);
    busoff <= 1'b0;
    dup_addr <= 1'b1;
    do_reset;
    wait_on(1, 1, 20);
    chk("dup", {16'h0, 2'b01, 8'hd0, 6'h00}, trio);
    complete_run;
  end
endmodule
